// *** common/serial_tx_defines.svh ***
// constants for the transmit word-select front end
// assumes inclusion by bare name from packages and modules
`ifndef SERIAL_TX_DEFINES_SVH
`define SERIAL_TX_DEFINES_SVH

`define WORD_W 16
`define CTRL_W 14
`define KIND_W 2
`define FRAME_W 19
`define BITCNT_W 5
`define FIFO_DEPTH 32
`define KIND_IDLE 2'h0
`define KIND_DATA 2'h1
`define KIND_CTRL 2'h2
`define LFSR_W 7
`define LFSR_SEED 7'h7f
`define LFSR_TAP_A 6
`define LFSR_TAP_B 5
`define BITCNT_LAST 5'h12
`define BITCNT_ZERO 5'h00
`define BITCNT_ONE 5'h01

`endif

// *** common/serial_tx_pkg.sv ***
// types shared by the word-select front end and its buffer
// assumes serial_tx_defines.svh is on the include path
`include "serial_tx_defines.svh"
package serial_tx_pkg;
	typedef logic [`FRAME_W-1:0] frame_t;
	typedef logic [`WORD_W-1:0] word_t;
	typedef enum logic [`KIND_W-1:0] {
		KIND_IDLE = 2'b00,
		KIND_DATA = 2'b01,
		KIND_CTRL = 2'b10
	} word_kind_t;
endpackage : serial_tx_pkg

// *** common/frame_if.sv ***
// valid/ready carrier for frames between the front end and its buffer
// assumes serial_tx_pkg is compiled first
`timescale 1ns/1ns
interface frame_if;
	import serial_tx_pkg::*;
	logic valid;
	logic ready;
	frame_t data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : frame_if

// *** core/frame_fifo.sv ***
// frame buffer: array storage plus a registered output stage
// assumes one clock, synchronous active-high reset from the top
`timescale 1ns/1ns
`include "serial_tx_defines.svh"
module frame_fifo #(
	parameter int WIDTH = `FRAME_W,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	frame_if.snk in_port,
	frame_if.src out_port
);
	import serial_tx_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic [WIDTH-1:0] out_data_reg;
	logic out_valid_reg;
	logic push;
	logic pop;
	logic stage_free;

	assign in_port.ready = (count_reg != FULL_CNT);
	assign push = ce && in_port.valid && in_port.ready;
	assign stage_free = !out_valid_reg || out_port.ready;
	assign pop = ce && stage_free && (count_reg != '0);
	assign out_port.valid = out_valid_reg;
	assign out_port.data = frame_t'(out_data_reg);

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr_reg] <= in_port.data;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

	// read data leave through a register so the array can be plain RAM
	always_ff @(posedge clk) begin
		if (rst) begin
			out_valid_reg <= 1'b0;
			out_data_reg <= '0;
		end else if (ce && stage_free) begin
			out_valid_reg <= (count_reg != '0);
			if (count_reg != '0)
				out_data_reg <= mem[rd_ptr_reg];
		end
	end
endmodule : frame_fifo

// *** core/serial_tx_word_select.sv ***
// transmit word-select front end: picks data, control or idle words,
// applies the flag bit policy and shifts frames out one bit per clock
// assumes SYS_CLK is the word clock and all user pins except CE are asynchronous
//
// Operation
// - with flag mode select high the extra flag bit rides as bit 18 of data words.
// - with flag scramble enable high the flag bit encoding is scrambled.
// - data request high with control request low sends bits 0-15 and flag as data.
// - control request high sends only bits 0-13 as a control word.
// - both requests high together give a control word.
// - both requests low give idle words.
// - with flag mode select low an alternating internal flag replaces the input.
// - control words never carry a flag bit.
// - a word's first serial bit leaves after a delay set by buffer fill and the next frame boundary.
`timescale 1ns/1ns
`include "serial_tx_defines.svh"
module serial_tx_word_select #(
	parameter int DEPTH = `FIFO_DEPTH
) (
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic CE,
	input wire serial_tx_pkg::word_t WORD_BITS,
	input wire logic EXTRA_FLAG_BIT,
	input wire logic DATA_WORD_REQUEST,
	input wire logic CONTROL_WORD_REQUEST,
	input wire logic FLAG_MODE_SELECT,
	input wire logic FLAG_SCRAMBLE_ENABLE,
	output logic TX_READY,
	output logic WORD_DROPPED,
	output logic SERIAL_LINE_OUT,
	output logic WORD_START,
	output serial_tx_pkg::word_kind_t WORD_KIND
);
	import serial_tx_pkg::*;

	logic [1:0] rst_sync_reg;
	logic rst;
	word_t word_meta_reg;
	word_t word_sync_reg;
	logic [4:0] ctl_meta_reg;
	logic [4:0] ctl_sync_reg;
	logic flag_in;
	logic data_req;
	logic ctrl_req;
	logic mode_sel;
	logic scr_en;
	logic alt_flag_reg;
	logic [`LFSR_W-1:0] lfsr_reg;
	logic [`LFSR_W-1:0] lfsr_next;
	logic flag_bit;
	frame_t frame_next;
	logic [`BITCNT_W-1:0] bit_cnt_reg;
	frame_t shift_reg;
	logic load;
	frame_t idle_frame;

	frame_if to_fifo ();
	frame_if from_fifo ();

	// reset asserts at once, releases through two flops
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst = !rst_sync_reg[1];

	// WORD_BITS and the five request, flag and mode pins pass two flops before any logic looks at them; CE does not
	always_ff @(posedge SYS_CLK) begin
		if (CE) begin
			word_meta_reg <= WORD_BITS;
			word_sync_reg <= word_meta_reg;
			ctl_meta_reg <= {FLAG_SCRAMBLE_ENABLE, FLAG_MODE_SELECT,
				CONTROL_WORD_REQUEST, DATA_WORD_REQUEST, EXTRA_FLAG_BIT};
			ctl_sync_reg <= ctl_meta_reg;
		end
	end
	assign flag_in = ctl_sync_reg[0];
	assign data_req = ctl_sync_reg[1];
	assign ctrl_req = ctl_sync_reg[2];
	assign mode_sel = ctl_sync_reg[3];
	assign scr_en = ctl_sync_reg[4];

	// scrambler steps once per data word so the far end can follow it
	assign lfsr_next = {lfsr_reg[`LFSR_W-2:0],
		lfsr_reg[`LFSR_TAP_A] ^ lfsr_reg[`LFSR_TAP_B]};

	always_comb begin
		flag_bit = mode_sel ? flag_in : alt_flag_reg;
		if (scr_en)
			flag_bit = flag_bit ^ lfsr_reg[0];
		if (ctrl_req) begin
			frame_next = {1'b0, {(`WORD_W-`CTRL_W){1'b0}},
				word_sync_reg[`CTRL_W-1:0], KIND_CTRL};
		end else begin
			frame_next = {flag_bit, word_sync_reg, KIND_DATA};
		end
	end

	assign to_fifo.valid = CE && !rst && (data_req || ctrl_req);
	assign to_fifo.data = frame_next;

	always_ff @(posedge SYS_CLK) begin
		if (rst) begin
			alt_flag_reg <= 1'b0;
			lfsr_reg <= `LFSR_SEED;
		end else if (to_fifo.valid && to_fifo.ready && !ctrl_req) begin
			alt_flag_reg <= !alt_flag_reg;
			lfsr_reg <= lfsr_next;
		end
	end

	// words that meet a full buffer are lost; the pulse tells the user
	always_ff @(posedge SYS_CLK) begin
		if (rst)
			WORD_DROPPED <= 1'b0;
		else if (CE)
			WORD_DROPPED <= to_fifo.valid && !to_fifo.ready;
	end

	assign TX_READY = to_fifo.ready;

	frame_fifo #(
		.WIDTH(`FRAME_W),
		.DEPTH(DEPTH)
	) buffer (
		.clk(SYS_CLK),
		.rst(rst),
		.ce(CE),
		.in_port(to_fifo.snk),
		.out_port(from_fifo.src)
	);

	// an empty buffer at a frame boundary means an idle word goes out
	assign idle_frame = {{(`FRAME_W-`KIND_W){1'b0}}, KIND_IDLE};
	assign load = CE && (bit_cnt_reg == `BITCNT_LAST);
	assign from_fifo.ready = load;

	always_ff @(posedge SYS_CLK) begin
		if (rst) begin
			bit_cnt_reg <= `BITCNT_LAST;
			shift_reg <= '0;
		end else if (load) begin
			bit_cnt_reg <= `BITCNT_ZERO;
			shift_reg <= from_fifo.valid ? from_fifo.data : idle_frame;
		end else if (CE) begin
			bit_cnt_reg <= bit_cnt_reg + `BITCNT_ONE;
			shift_reg <= {1'b0, shift_reg[`FRAME_W-1:1]};
		end
	end

	// output flop keeps the line free of glitches
	always_ff @(posedge SYS_CLK) begin
		if (rst) begin
			SERIAL_LINE_OUT <= 1'b0;
			WORD_START <= 1'b0;
			WORD_KIND <= KIND_IDLE;
		end else if (CE) begin
			SERIAL_LINE_OUT <= shift_reg[0];
			WORD_START <= (bit_cnt_reg == `BITCNT_ZERO);
			if (bit_cnt_reg == `BITCNT_ZERO)
				WORD_KIND <= word_kind_t'(shift_reg[`KIND_W-1:0]);
		end
	end
endmodule : serial_tx_word_select

// *** tb/serial_tx_word_select_chk.sv ***
// checker: frame shape and drop timing seen at the top ports
// assumes CE is held high by the bench
`timescale 1ns/1ns
module serial_tx_word_select_chk (
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic DATA_WORD_REQUEST,
	input wire logic CONTROL_WORD_REQUEST,
	input wire logic TX_READY,
	input wire logic WORD_DROPPED,
	input wire logic SERIAL_LINE_OUT,
	input wire logic WORD_START,
	input wire serial_tx_pkg::word_kind_t WORD_KIND
);
	import serial_tx_pkg::*;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	wire logic z = !SERIAL_LINE_OUT;
	wire logic req = DATA_WORD_REQUEST | CONTROL_WORD_REQUEST;
	wire logic ctl = WORD_START && WORD_KIND == KIND_CTRL;
	sequence s_zero8;
		z [*8];
	endsequence
	AST_IDLE: assert property (WORD_START && WORD_KIND == KIND_IDLE
		|-> s_zero8 ##1 s_zero8 ##1 z [*3]) else $error("idle frame not zero");
	AST_KIND: assert property (WORD_START |->
		SERIAL_LINE_OUT == WORD_KIND[0] ##1 SERIAL_LINE_OUT == WORD_KIND[1])
		else $error("kind bits wrong");
	AST_CHI: assert property (ctl |-> ##16 z ##1 z)
		else $error("control word high bits sent");
	AST_CFLG: assert property (ctl |-> ##18 z)
		else $error("control word carries a flag");
	AST_PER: assert property (WORD_START |-> ##19 WORD_START)
		else $error("frame period wrong");
	AST_HOLD: assert property (WORD_START |=> $stable(WORD_KIND) [*8])
		else $error("kind changed in frame");
	AST_DROP: assert property (WORD_DROPPED |-> $past(req, 3) || $past(req, 4))
		else $error("drop without request");
	AST_RDY: assert property (!TX_READY |-> ##[1:60] TX_READY)
		else $error("buffer never drains");
endmodule : serial_tx_word_select_chk
bind serial_tx_word_select serial_tx_word_select_chk i_chk (.SYS_CLK(SYS_CLK),
	.RSTN(RSTN), .DATA_WORD_REQUEST(DATA_WORD_REQUEST),
	.CONTROL_WORD_REQUEST(CONTROL_WORD_REQUEST), .TX_READY(TX_READY),
	.WORD_DROPPED(WORD_DROPPED), .SERIAL_LINE_OUT(SERIAL_LINE_OUT),
	.WORD_START(WORD_START), .WORD_KIND(WORD_KIND));

// *** tb/serial_rx_model.sv ***
// far-end receiver model: rebuilds frames and recovers the data flag
// assumes WORD_START marks bit 0 of every frame
`timescale 1ns/1ns
module serial_rx_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic line,
	input wire logic start,
	input wire logic far_flag_scramble_enable,
	output serial_tx_pkg::frame_t frame,
	output logic got,
	output logic flag
);
	import serial_tx_pkg::*;
	frame_t sh;
	logic [4:0] n = 5'h13;
	logic [6:0] lfsr;
	always @(posedge clk) begin
		got <= 1'h0;
		if (start)
			n = 5'h0;
		if (n < 5'h13)
			sh[n] = line;
		if (n == 5'h12) begin
			frame <= sh;
			got <= 1'h1;
		end
		// scrambler steps on data words only, as on the sending side
		if (n == 5'h12 && sh[1:0] == KIND_DATA) begin
			flag <= sh[18] ^ (far_flag_scramble_enable & lfsr[0]);
			lfsr = {lfsr[5:0], lfsr[6] ^ lfsr[5]};
		end
		if (!rstn)
			lfsr = 7'h7f;
		n = (n < 5'h13) ? n + 5'h1 : n;
	end
endmodule : serial_rx_model

// *** tb/serial_tx_word_select_tb.sv ***
// bench: reset checks, table of single words, then idle and overflow cases
// assumes serial_rx_model as the far end
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	bad_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module serial_tx_word_select_tb;
	import serial_tx_pkg::*;
	typedef struct packed {logic c, d, m, s; word_t w; logic f;} row_t;
	row_t rows [6] = '{'{1'h0, 1'h1, 1'h1, 1'h1, 16'h8001, 1'h1},
		'{1'h0, 1'h1, 1'h1, 1'h0, 16'hc3a5, 1'h0},
		'{1'h1, 1'h0, 1'h1, 1'h1, 16'hffff, 1'h1},
		'{1'h1, 1'h1, 1'h1, 1'h1, 16'h4321, 1'h1},
		'{1'h0, 1'h1, 1'h0, 1'h0, 16'h0f0f, 1'h1},
		'{1'h0, 1'h1, 1'h0, 1'h1, 16'hf00f, 1'h1}};
	logic SYS_CLK = 1'h0, RSTN = 1'h0, EXTRA_FLAG_BIT = 1'h0;
	logic DATA_WORD_REQUEST = 1'h0, CONTROL_WORD_REQUEST = 1'h0;
	logic FLAG_MODE_SELECT = 1'h1, FLAG_SCRAMBLE_ENABLE = 1'h1;
	word_t WORD_BITS = 16'h0;
	logic TX_READY, WORD_DROPPED, SERIAL_LINE_OUT, WORD_START, got, flag, pf;
	word_kind_t WORD_KIND, k;
	frame_t fr;
	int bad_count = 0, n_checks = 0, drops = 0, ndata = 0, n;
	always #25 SYS_CLK = ~SYS_CLK;
	serial_tx_word_select i_serial_tx_word_select (.SYS_CLK(SYS_CLK),
		.RSTN(RSTN), .CE(1'h1), .WORD_BITS(WORD_BITS),
		.EXTRA_FLAG_BIT(EXTRA_FLAG_BIT), .DATA_WORD_REQUEST(DATA_WORD_REQUEST),
		.CONTROL_WORD_REQUEST(CONTROL_WORD_REQUEST),
		.FLAG_MODE_SELECT(FLAG_MODE_SELECT), .TX_READY(TX_READY),
		.FLAG_SCRAMBLE_ENABLE(FLAG_SCRAMBLE_ENABLE),
		.WORD_DROPPED(WORD_DROPPED), .SERIAL_LINE_OUT(SERIAL_LINE_OUT),
		.WORD_START(WORD_START), .WORD_KIND(WORD_KIND));
	// far end follows the same scramble level; mode needs no decoding here
	serial_rx_model i_serial_rx_model (.clk(SYS_CLK), .rstn(RSTN),
		.line(SERIAL_LINE_OUT), .start(WORD_START), .frame(fr), .got(got),
		.far_flag_scramble_enable(FLAG_SCRAMBLE_ENABLE), .flag(flag));
	always @(negedge SYS_CLK) begin
		drops += (WORD_DROPPED === 1'h1);
		ndata += (got === 1'h1 && fr[1:0] === KIND_DATA);
	end
	task automatic finish_test();
		if (bad_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test
	task automatic wait_frame(input word_kind_t kd);
		n = 0;
		do begin
			@(negedge SYS_CLK);
			n++;
		end while (!(got === 1'h1 && fr[1:0] === kd) && n < 300);
		if (n >= 300) begin
			bad_count++;
			finish_test();
		end
	endtask : wait_frame
	initial begin
		repeat (4) @(negedge SYS_CLK);
		`CHK("ready_rst", 1'h1, TX_READY)
		`CHK("kind_rst", KIND_IDLE, WORD_KIND)
		RSTN = 1'h1;
		foreach (rows[i]) begin
			{FLAG_MODE_SELECT, FLAG_SCRAMBLE_ENABLE} = {rows[i].m, rows[i].s};
			{WORD_BITS, EXTRA_FLAG_BIT} = {rows[i].w, rows[i].f};
			repeat (3) @(negedge SYS_CLK);
			{CONTROL_WORD_REQUEST, DATA_WORD_REQUEST} = {rows[i].c, rows[i].d};
			@(negedge SYS_CLK);
			{CONTROL_WORD_REQUEST, DATA_WORD_REQUEST} = 2'h0;
			k = rows[i].c ? KIND_CTRL : KIND_DATA;
			wait_frame(k);
			`CHK("frame", {rows[i].c ? {2'h0, rows[i].w[13:0]} : rows[i].w, k}, fr[17:0])
			if (rows[i].c)
				`CHK("cflag", 1'h0, fr[18])
			else if (rows[i].m)
				`CHK("uflag", rows[i].f, flag)
			else if (i == 5)
				`CHK("alt", !pf, flag)
			pf = flag;
		end
		FLAG_MODE_SELECT = 1'h1;
		wait_frame(KIND_IDLE);
		`CHK("idle", 19'h0, fr)
		{drops, ndata, DATA_WORD_REQUEST} = {32'h0, 32'h0, 1'h1};
		repeat (45) @(negedge SYS_CLK);
		DATA_WORD_REQUEST = 1'h0;
		for (n = 0; n < 1500 && ndata != 45 - drops; n++)
			@(negedge SYS_CLK);
		`CHK("drop", 1'h1, drops > 0)
		`CHK("sent", 45 - drops, ndata)
		finish_test();
	end
endmodule : serial_tx_word_select_tb
